//--- dpdio_pkg.sv
// Package for the dual parallel port digital I/O board logic.
package dpdio_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int CTRL_COUNT = 2;
    localparam int PORT_COUNT = 3;
    localparam int PORT_W = 8;
    localparam int JMP_W = 6;
    localparam int ADDR_W = 10;

    // ****************************************************************
    // Window offsets within the 16-byte decode
    // ****************************************************************
    localparam logic [1:0] OFF_PORT_A = 2'h0;
    localparam logic [1:0] OFF_PORT_B = 2'h1;
    localparam logic [1:0] OFF_PORT_C = 2'h2;
    localparam logic [1:0] OFF_CTRL = 2'h3;
    localparam int OFF_CTRL_SEL_BIT = 2;
    localparam int OFF_HOLE_BIT = 3;
    localparam int ADDR_WIN_LO = 4;
    localparam int ADDR_WIN_HI = 9;

    // ****************************************************************
    // Control byte fields and common values
    // ****************************************************************
    localparam int CW_MODE_SET_BIT = 7;
    localparam int CW_A_IN_BIT = 4;
    localparam int CW_CU_IN_BIT = 3;
    localparam int CW_B_IN_BIT = 1;
    localparam int CW_CL_IN_BIT = 0;
    localparam int CW_BSR_VAL_BIT = 0;
    localparam int CW_BSR_SEL_LO = 1;
    localparam int CW_BSR_SEL_HI = 3;
    localparam logic [7:0] CW_ALL_IN = 8'h9B;
    localparam logic [7:0] CW_ALL_OUT = 8'h80;
    localparam logic [7:0] CW_AB_IN_C_OUT = 8'h92;
    localparam logic [7:0] CW_RESET = CW_ALL_IN;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam int IRQ_BIT = 0;

    // ****************************************************************
    // Base address straps
    // ****************************************************************
    localparam logic [5:0] JMP_DELIVERED = 6'h30;
    localparam logic [9:0] BASE_DELIVERED = 10'h300;

    // ****************************************************************
    // Block state
    // ****************************************************************
    typedef logic [CTRL_COUNT-1:0][PORT_COUNT-1:0][PORT_W-1:0] dpdio_lines_t;

    typedef struct packed {
        logic ior_n_m;
        logic ior_n_s;
        logic iow_n_m;
        logic iow_n_s;
        logic iow_n_d;
        logic aen_m;
        logic aen_s;
        logic [ADDR_W-1:0] addr_m;
        logic [ADDR_W-1:0] addr_s;
        logic [PORT_W-1:0] data_m;
        logic [PORT_W-1:0] data_s;
        logic [JMP_W-1:0] jmp_m;
        logic [JMP_W-1:0] jmp_s;
        dpdio_lines_t pin_m;
        dpdio_lines_t pin_s;
        dpdio_lines_t latch;
        logic [CTRL_COUNT-1:0][PORT_W-1:0] ctrl;
        logic wr_pend;
        logic [3:0] wr_off;
        logic [PORT_W-1:0] wr_data;
        logic [PORT_W-1:0] rdata;
        logic drive;
        logic [CTRL_COUNT-1:0] irq;
    } dpdio_state_t;

endpackage

//--- dpdio_board.sv
// Host bus decode, two parallel port controllers and their line pins.
// Operation
// - Open jumper reads one, fitted reads zero.
// - Address bits 9..4 match jumpers selects window.
// - Leftmost jumper is bit 9, rightmost bit 4.
// - Delivered straps give base address 300 hex.
// - Offsets 0..3: first controller A, B, C, control.
// - Offsets 4..7: second controller A, B, C, control.
// - Offsets 3 and 7 are control registers.
// - Port bit n is line n.
// - Control write with bit 7 set sets direction and mode.
// - 9B all inputs, 80 all outputs, 92 C out.
// - Line C0 of each controller requests interrupt.
// - Direction per group: A, B, C halves.
// - Host data path is single bytes only.
// - 48 lines, 24 per controller header.
`timescale 1ns/1ps
module dpdio_board
    import dpdio_pkg::*;
(
    input wire logic i_sys_clk, // System clock, 100 MHz.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire logic [ADDR_W-1:0] i_isa_addr, // Host I/O address.
    input wire logic i_isa_aen, // Host DMA address enable.
    input wire logic i_isa_ior_n, // Host I/O read strobe.
    input wire logic i_isa_iow_n, // Host I/O write strobe.
    input wire logic [PORT_W-1:0] i_isa_data, // Host write data.
    output logic [PORT_W-1:0] o_isa_data, // Host read data.
    output logic o_isa_data_oe_n, // Low while driving host data.
    input wire logic [JMP_W-1:0] i_base_address_jumper_header, // Straps.
    input wire logic [PORT_W-1:0] i_first_ctrl_a_line_bits, // Pins.
    output logic [PORT_W-1:0] o_first_ctrl_a_line_bits, // Drive.
    output logic [PORT_W-1:0] o_first_ctrl_a_line_oe_n, // Low drives.
    input wire logic [PORT_W-1:0] i_first_ctrl_b_line_bits, // Pins.
    output logic [PORT_W-1:0] o_first_ctrl_b_line_bits, // Drive.
    output logic [PORT_W-1:0] o_first_ctrl_b_line_oe_n, // Low drives.
    input wire logic [PORT_W-1:0] i_first_ctrl_c_line_bits, // Pins.
    output logic [PORT_W-1:0] o_first_ctrl_c_line_bits, // Drive.
    output logic [PORT_W-1:0] o_first_ctrl_c_line_oe_n, // Low drives.
    input wire logic [PORT_W-1:0] i_second_ctrl_a_line_bits, // Pins.
    output logic [PORT_W-1:0] o_second_ctrl_a_line_bits, // Drive.
    output logic [PORT_W-1:0] o_second_ctrl_a_line_oe_n, // Low drives.
    input wire logic [PORT_W-1:0] i_second_ctrl_b_line_bits, // Pins.
    output logic [PORT_W-1:0] o_second_ctrl_b_line_bits, // Drive.
    output logic [PORT_W-1:0] o_second_ctrl_b_line_oe_n, // Low drives.
    input wire logic [PORT_W-1:0] i_second_ctrl_c_line_bits, // Pins.
    output logic [PORT_W-1:0] o_second_ctrl_c_line_bits, // Drive.
    output logic [PORT_W-1:0] o_second_ctrl_c_line_oe_n, // Low drives.
    output logic [CTRL_COUNT-1:0] o_interrupt_capable_line_req // C0 levels.
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Whether a line group is an input under a control byte.
    function automatic logic grp_in(input logic [7:0] cw,
                                    input logic [1:0] p,
                                    input int b);
        logic r;
        case (p)
            OFF_PORT_A: r = cw[CW_A_IN_BIT];
            OFF_PORT_B: r = cw[CW_B_IN_BIT];
            default: r = (b >= 4) ? cw[CW_CU_IN_BIT] : cw[CW_CL_IN_BIT];
        endcase
        return r;
    endfunction

    // Host view of a port: input groups show pins, output groups latches.
    function automatic logic [7:0] port_view(input logic [7:0] cw,
                                             input logic [1:0] p,
                                             input logic [7:0] pins,
                                             input logic [7:0] lat);
        logic [7:0] v;
        v = '0;
        for (int b = 0; b < PORT_W; b++) begin
            v[b] = grp_in(cw, p, b) ? pins[b] : lat[b];
        end
        return v;
    endfunction

    // ****************************************************************
    // Pin gathering
    // ****************************************************************
    dpdio_state_t st_r;
    dpdio_state_t st_nxt;
    dpdio_lines_t pins_in;
    dpdio_lines_t lines_oe_n;
    logic sel;
    logic [3:0] off;
    logic rd_hit;
    logic wr_rise;
    logic [PORT_W-1:0] rd_val;
    logic [PORT_W-1:0] c_view;

    // Both controllers carry 24 lines each on their own header.
    assign pins_in[0][0] = i_first_ctrl_a_line_bits;
    assign pins_in[0][1] = i_first_ctrl_b_line_bits;
    assign pins_in[0][2] = i_first_ctrl_c_line_bits;
    assign pins_in[1][0] = i_second_ctrl_a_line_bits;
    assign pins_in[1][1] = i_second_ctrl_b_line_bits;
    assign pins_in[1][2] = i_second_ctrl_c_line_bits;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Host strobes are asynchronous, so every bus input is synchronised
    // first; this costs a few cycles of the long ISA strobe, no more.
    always_comb begin
        st_nxt = st_r;
        st_nxt.ior_n_m = i_isa_ior_n;
        st_nxt.ior_n_s = st_r.ior_n_m;
        st_nxt.iow_n_m = i_isa_iow_n;
        st_nxt.iow_n_s = st_r.iow_n_m;
        st_nxt.iow_n_d = st_r.iow_n_s;
        st_nxt.aen_m = i_isa_aen;
        st_nxt.aen_s = st_r.aen_m;
        st_nxt.addr_m = i_isa_addr;
        st_nxt.addr_s = st_r.addr_m;
        st_nxt.data_m = i_isa_data;
        st_nxt.data_s = st_r.data_m;
        st_nxt.jmp_m = i_base_address_jumper_header;
        st_nxt.jmp_s = st_r.jmp_m;
        st_nxt.pin_m = pins_in;
        st_nxt.pin_s = st_r.pin_m;

        // Leftmost strap is the top bit of the six-bit compare.
        sel = !st_r.aen_s
            && (st_r.addr_s[ADDR_WIN_HI:ADDR_WIN_LO]
                == st_r.jmp_s);
        off = st_r.addr_s[3:0];
        rd_hit = sel && !st_r.ior_n_s && !off[OFF_HOLE_BIT];

        // Read mux: offset bit 2 picks the controller, bits 1..0 the port.
        if (off[1:0] == OFF_CTRL) begin
            rd_val = st_r.ctrl[off[OFF_CTRL_SEL_BIT]];
        end else begin
            rd_val = port_view(st_r.ctrl[off[OFF_CTRL_SEL_BIT]],
                off[1:0],
                st_r.pin_s[off[OFF_CTRL_SEL_BIT]][off[1:0]],
                st_r.latch[off[OFF_CTRL_SEL_BIT]][off[1:0]]);
        end
        st_nxt.drive = rd_hit;
        if (rd_hit) begin
            st_nxt.rdata = rd_val;
        end

        // Write data may go away soon after the strobe rises, so the last
        // value seen while the strobe is low is committed at its end.
        if (sel && !st_r.iow_n_s && !off[OFF_HOLE_BIT]) begin
            st_nxt.wr_pend = 1'b1;
            st_nxt.wr_off = off;
            st_nxt.wr_data = st_r.data_s;
        end
        wr_rise = !st_r.iow_n_d && st_r.iow_n_s;
        if (wr_rise && st_r.wr_pend) begin
            st_nxt.wr_pend = 1'b0;
            if (st_r.wr_off[1:0] != OFF_CTRL) begin
                st_nxt.latch[st_r.wr_off[OFF_CTRL_SEL_BIT]]
                    [st_r.wr_off[1:0]] = st_r.wr_data;
            end else if (st_r.wr_data[CW_MODE_SET_BIT]) begin
                // A mode byte sets directions and clears that controller's
                // output latches, as the classic controller does.
                st_nxt.ctrl[st_r.wr_off[OFF_CTRL_SEL_BIT]] =
                    st_r.wr_data;
                st_nxt.latch[st_r.wr_off[OFF_CTRL_SEL_BIT]] = '0;
            end else begin
                // Bit 7 clear: single bit set or reset on port C.
                st_nxt.latch[st_r.wr_off[OFF_CTRL_SEL_BIT]][OFF_PORT_C]
                    [st_r.wr_data[CW_BSR_SEL_HI:CW_BSR_SEL_LO]]
                    = st_r.wr_data[CW_BSR_VAL_BIT];
            end
        end

        // Line C0 as seen by the host raises the request of its controller.
        // The whole port view is held in a variable, since a bit cannot be
        // selected straight out of a function result.
        c_view = '0;
        for (int c = 0; c < CTRL_COUNT; c++) begin
            c_view = port_view(st_r.ctrl[c], OFF_PORT_C,
                st_r.pin_s[c][OFF_PORT_C],
                st_r.latch[c][OFF_PORT_C]);
            st_nxt.irq[c] = c_view[IRQ_BIT];
        end

        // Reset leaves every controller in the all-input mode.
        if (i_srst) begin
            st_nxt = '0;
            st_nxt.ior_n_m = 1'b1;
            st_nxt.ior_n_s = 1'b1;
            st_nxt.iow_n_m = 1'b1;
            st_nxt.iow_n_s = 1'b1;
            st_nxt.iow_n_d = 1'b1;
            st_nxt.aen_m = 1'b1;
            st_nxt.aen_s = 1'b1;
            st_nxt.ctrl = {CTRL_COUNT{CW_RESET}};
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // One register holds all state; reset is applied in the next-state logic.
    always_ff @(posedge i_sys_clk) begin
        st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Enables follow the stored control byte per group.
    always_comb begin
        for (int c = 0; c < CTRL_COUNT; c++) begin
            for (int p = 0; p < PORT_COUNT; p++) begin
                for (int b = 0; b < PORT_W; b++) begin
                    lines_oe_n[c][p][b] =
                        grp_in(st_r.ctrl[c], 2'(p), b);
                end
            end
        end
    end

    assign o_isa_data = st_r.rdata;
    assign o_isa_data_oe_n = !st_r.drive;
    assign o_interrupt_capable_line_req = st_r.irq;
    assign o_first_ctrl_a_line_bits = st_r.latch[0][0];
    assign o_first_ctrl_b_line_bits = st_r.latch[0][1];
    assign o_first_ctrl_c_line_bits = st_r.latch[0][2];
    assign o_second_ctrl_a_line_bits = st_r.latch[1][0];
    assign o_second_ctrl_b_line_bits = st_r.latch[1][1];
    assign o_second_ctrl_c_line_bits = st_r.latch[1][2];
    assign o_first_ctrl_a_line_oe_n = lines_oe_n[0][0];
    assign o_first_ctrl_b_line_oe_n = lines_oe_n[0][1];
    assign o_first_ctrl_c_line_oe_n = lines_oe_n[0][2];
    assign o_second_ctrl_a_line_oe_n = lines_oe_n[1][0];
    assign o_second_ctrl_b_line_oe_n = lines_oe_n[1][1];
    assign o_second_ctrl_c_line_oe_n = lines_oe_n[1][2];

    // ****************************************************************
    // Assertions
    // ****************************************************************

    // Host data is driven only for a decoded hit below offset 8.
    drive_window_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        !o_isa_data_oe_n |-> $past(sel) && !$past(st_r.ior_n_s)
            && !$past(st_r.addr_s[OFF_HOLE_BIT]))
        else $error("host data driven outside the register window");

    // With delivered straps only the window at 300 hex is selected.
    default_base_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (st_r.jmp_s == JMP_DELIVERED && sel)
        |-> st_r.addr_s[ADDR_WIN_HI:ADDR_WIN_LO]
            == BASE_DELIVERED[ADDR_WIN_HI:ADDR_WIN_LO])
        else $error("delivered straps decode a wrong base");

    // A mode byte to offset 3 lands in the first control register.
    ctrl_write_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (wr_rise && st_r.wr_pend && st_r.wr_off == 4'h3
            && st_r.wr_data[CW_MODE_SET_BIT])
        |=> st_r.ctrl[0] == $past(st_r.wr_data))
        else $error("control byte not stored");

    // Offset 4 writes port A of the second controller.
    second_port_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (wr_rise && st_r.wr_pend && st_r.wr_off == 4'h4)
        |=> st_r.latch[1][0] == $past(st_r.wr_data))
        else $error("offset 4 write lost");

    // All-input byte releases every line of the first controller.
    all_input_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        st_r.ctrl[0] == CW_ALL_IN
        |-> (&o_first_ctrl_a_line_oe_n) && (&o_first_ctrl_b_line_oe_n)
            && (&o_first_ctrl_c_line_oe_n))
        else $error("all-input mode still drives lines");

    // Port C halves follow their own direction bits.
    c_halves_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_first_ctrl_c_line_oe_n
            == {{4{st_r.ctrl[0][CW_CU_IN_BIT]}},
                {4{st_r.ctrl[0][CW_CL_IN_BIT]}}})
        else $error("port C half direction wrong");

    // Reading an input port A returns the synchronised pins.
    input_read_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (rd_hit && off == 4'h0 && st_r.ctrl[0][CW_A_IN_BIT])
        |=> o_isa_data == $past(st_r.pin_s[0][0])
            && !o_isa_data_oe_n)
        else $error("input port read mismatch");

    // Request follows synchronised line C0 of the first controller one cycle later.
    irq_follow_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (st_r.ctrl[0][CW_CL_IN_BIT] && !$past(i_srst))
        |=> o_interrupt_capable_line_req[0]
            == $past(st_r.pin_s[0][2][IRQ_BIT]))
        else $error("interrupt request does not follow C0");

    // A bit command with bit 7 clear must leave the control bytes alone.
    bit_cmd_a: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        (wr_rise && st_r.wr_pend && st_r.wr_off[1:0] == OFF_CTRL
            && !st_r.wr_data[CW_MODE_SET_BIT])
        |=> $stable(st_r.ctrl))
        else $error("bit command changed a control byte");

endmodule // dpdio_board

//--- dpdio_host.sv
// Host processor model that runs byte cycles on the board's I/O bus.
`timescale 1ns/1ps
module dpdio_host
    import dpdio_pkg::*;
(
    input wire logic i_clk, // Bus clock.
    input wire logic [PORT_W-1:0] i_data, // Board read data.
    input wire logic i_data_oe_n, // Low while the board drives data.
    output logic [ADDR_W-1:0] o_addr, // I/O address.
    output logic o_aen, // High marks a DMA cycle.
    output logic o_ior_n, // Read strobe, active low.
    output logic o_iow_n, // Write strobe, active low.
    output logic [PORT_W-1:0] o_data // Write data.
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Idle bus at time zero; the data lines start as a floating pattern.
    initial begin
        o_addr = '0;
        o_aen = 1'b0;
        o_ior_n = 1'b1;
        o_iow_n = 1'b1;
        o_data = 8'hFF;
    end

    // One byte write; the gap after it keeps strobes well apart.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_data <= d;
        o_iow_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        o_iow_n <= 1'b1;
        @(posedge i_clk);
        // Released data lines must not keep looking like the last byte.
        o_data <= ~d;
        repeat (6) @(posedge i_clk);
    endtask

    // One byte read; ok stays low when the board never answers.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [PORT_W-1:0] q,
                      output logic ok);
        int i;
        ok = 1'b0;
        q = '0;
        @(posedge i_clk);
        o_addr <= a;
        o_ior_n <= 1'b0;
        for (i = 0; i < 8 && !ok; i++) begin
            @(posedge i_clk);
            if (i_data_oe_n === 1'b0) begin
                ok = 1'b1;
                q = i_data;
            end
        end
        o_ior_n <= 1'b1;
        repeat (5) @(posedge i_clk);
    endtask
endmodule // dpdio_host

//--- dual_ppi_digital_io_board_bench.sv
// Self-checking bench for the dual parallel port board logic.
`timescale 1ns/1ps
module dual_ppi_digital_io_board_bench;
    import dpdio_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [JMP_W-1:0] jmp = 6'h30;
    wire dpdio_lines_t dq, doe;
    dpdio_lines_t pin;
    dpdio_lines_t ext = '0;
    dpdio_lines_t ext_msk = '0;
    logic [ADDR_W-1:0] a;
    logic aen, ior_n, iow_n, isa_oe_n, ok;
    logic [7:0] hd, isa_q, rd_q, wv, e, cw;
    logic [1:0] irq;
    logic [9:0] base = 10'h300;
    int error_cnt = 0;
    int n_compared = 0;
    int r, k, p;
    // Control byte, then expected drive enables of ports A, B and C.
    logic [31:0] rows [10] = '{32'h9BFF_FFFF, 32'h92FF_FF00, 32'h99FF_00FF,
        32'h90FF_0000, 32'h8B00_FFFF, 32'h8200_FF00, 32'h8900_00FF,
        32'h8000_0000, 32'h8800_00F0, 32'h8100_000F};

    always #5 i_sys_clk = ~i_sys_clk;

    // Board drive wins, then the bench's line driver, else the pull-up.
    assign pin = (~doe & dq) | (doe & ext_msk & ext) | (doe & ~ext_msk);

    dpdio_host host_u (.i_clk(i_sys_clk), .i_data(isa_q),
        .i_data_oe_n(isa_oe_n), .o_addr(a), .o_aen(aen), .o_ior_n(ior_n),
        .o_iow_n(iow_n), .o_data(hd));

    dpdio_board dut_u (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_isa_addr(a), .i_isa_aen(aen), .i_isa_ior_n(ior_n),
        .i_isa_iow_n(iow_n), .i_isa_data(hd), .o_isa_data(isa_q),
        .o_isa_data_oe_n(isa_oe_n), .i_base_address_jumper_header(jmp),
        .i_first_ctrl_a_line_bits(pin[0][0]),
        .o_first_ctrl_a_line_bits(dq[0][0]),
        .o_first_ctrl_a_line_oe_n(doe[0][0]),
        .i_first_ctrl_b_line_bits(pin[0][1]),
        .o_first_ctrl_b_line_bits(dq[0][1]),
        .o_first_ctrl_b_line_oe_n(doe[0][1]),
        .i_first_ctrl_c_line_bits(pin[0][2]),
        .o_first_ctrl_c_line_bits(dq[0][2]),
        .o_first_ctrl_c_line_oe_n(doe[0][2]),
        .i_second_ctrl_a_line_bits(pin[1][0]),
        .o_second_ctrl_a_line_bits(dq[1][0]),
        .o_second_ctrl_a_line_oe_n(doe[1][0]),
        .i_second_ctrl_b_line_bits(pin[1][1]),
        .o_second_ctrl_b_line_bits(dq[1][1]),
        .o_second_ctrl_b_line_oe_n(doe[1][1]),
        .i_second_ctrl_c_line_bits(pin[1][2]),
        .o_second_ctrl_c_line_bits(dq[1][2]),
        .o_second_ctrl_c_line_oe_n(doe[1][2]),
        .o_interrupt_capable_line_req(irq));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    // Every comparison is counted; an unknown never counts as a match.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A read that must be answered, with the byte it must return.
    task automatic rdchk(input logic [9:0] ad, input logic [7:0] exp);
        host_u.rd(ad, rd_q, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd_q, exp);
    endtask

    // A read that the board must leave unanswered.
    task automatic rdmiss(input logic [9:0] ad);
        host_u.rd(ad, rd_q, ok);
        chk({7'h0, ok}, 8'h00);
    endtask

    // Reset for three edges, then everything must be an undriven input.
    task automatic reset_chk();
        i_srst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        @(posedge i_sys_clk);
        for (int c = 0; c < 2; c++) begin
            for (int q = 0; q < 3; q++) chk(doe[c][q], 8'hFF);
        end
        rdchk(base + 10'h3, CW_ALL_IN);
        rdchk(base + 10'h7, CW_ALL_IN);
    endtask

    task automatic print_verdict();
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        reset_chk();
        // Undriven input lines read high through the pull-ups.
        rdchk(base + 10'h4, 8'hFF);
        ext_msk <= '1;
        // Ten control bytes on both controllers, ports read back.
        for (r = 0; r < 10; r++) begin
            for (k = 0; k < 2; k++) begin
                cw = rows[r][31:24];
                for (p = 0; p < 3; p++) ext[k][p] <= ~(8'h5A ^ 8'(r*16+k*4+p));
                host_u.wr(base + 10'(k*4+3), cw);
                for (p = 0; p < 3; p++) begin
                    e = rows[r][23-8*p -: 8];
                    wv = 8'h5A ^ 8'(r*16+k*4+p);
                    chk(doe[k][p], e);
                    host_u.wr(base + 10'(k*4+p), wv);
                end
                for (p = 0; p < 3; p++) begin
                    e = rows[r][23-8*p -: 8];
                    wv = 8'h5A ^ 8'(r*16+k*4+p);
                    rdchk(base + 10'(k*4+p), (e & ~wv) | (~e & wv));
                    chk(dq[k][p] & ~e, wv & ~e);
                    if (p == 2) begin
                        chk({7'h0, irq[k]}, {7'h0, e[0] ^ wv[0]});
                    end
                end
                rdchk(base + 10'(k*4+3), cw);
            end
        end
        // Moved straps move the window; the old base stops answering.
        jmp <= 6'h22;
        repeat (3) @(posedge i_sys_clk);
        rdchk(10'h223, 8'h81);
        rdmiss(10'h303);
        jmp <= 6'h30;
        repeat (3) @(posedge i_sys_clk);
        // Upper half of the window holds nothing and must stay silent.
        for (r = 8; r < 16; r++) rdmiss(base + 10'(r));
        host_u.wr(base + 10'hB, 8'h80);
        // Bit command: bit 7 clear resets line C7 of the first controller.
        host_u.wr(base + 10'h3, 8'h0E);
        chk(dq[0][2], 8'h48);
        rdchk(base + 10'h3, 8'h81);
        // DMA cycles are ignored for both directions.
        host_u.o_aen <= 1'b1;
        host_u.wr(base + 10'h3, 8'h9B);
        rdmiss(base + 10'h3);
        host_u.o_aen <= 1'b0;
        rdchk(base + 10'h3, 8'h81);
        reset_chk();
        print_verdict();
    end
endmodule // dual_ppi_digital_io_board_bench
